// ==== src/cesr_map.svh ====
/*
  Register offsets, field positions, reset values and valid-bit masks
  of the charger event, status, command and mask bytes.
  Assumes the serial engine presents one byte access at a time on
  an 8-bit register address.
*/
// Overview of operation
// RULE_01 - Flag byte two bit 6 sets on main regulator over-current.
// RULE_02 - Flag byte two bit 5 sets on main output over-voltage.
// RULE_03 - Flag byte two bit 4 sets on main output CV or CC under-voltage.
// RULE_04 - Flag byte two bit 3 sets on auxiliary regulator under-voltage.
// RULE_05 - Flag byte two bit 2 sets on bias converter over-current.
// RULE_06 - Flag byte two bit 1 sets on bias converter over-voltage.
// RULE_07 - Flag byte two bit 0 sets on bias under-voltage; bit 7 reads zero.
// RULE_08 - Status bits 7 and 6 report sync clock too fast or too slow.
// RULE_09 - Status bit 5 is one while bias converter runs full duty.
// RULE_10 - Status bit 4 is one in constant-current, zero in constant-voltage.
// RULE_11 - Status bit 3 is one while main regulator runs full duty.
// RULE_12 - Status bit 2 shows main power-good; bits 1 and 0 read zero.
// RULE_13 - Status byte is read-only, live, and raises no interrupt.
// RULE_14 - Byte at 0x04 is reserved with no function.
// RULE_15 - Writing the command byte triggers its action besides storing.
// RULE_16 - Command bit 1 applies the staged voltage code; reads zero.
// RULE_17 - Command bit 0 enables main regulator; bits 7 to 2 unused.
// RULE_18 - A mask one stops the matching flag from raising an interrupt.
// RULE_19 - Global mask bit set forces every mask bit to one internally.
// RULE_20 - First mask bits 7,5,4,3,2,0 mask first flags; 6,1 unused.
// RULE_21 - Second mask bits 6 to 0 mask second flags; bit 7 unused.
// RULE_22 - Reading flags clears them if the cause has gone away.
// RULE_23 - Global mask bit resets to one, suppressing all interrupts.
// RULE_24 - Interrupt output high while any unmasked flag is one.
`ifndef CESR_MAP_SVH
`define CESR_MAP_SVH

// Register offsets.
`define CESR_ADDR_GEN_FLAGS  8'h01
`define CESR_ADDR_RAIL_FLAGS 8'h02
`define CESR_ADDR_LIVE       8'h03
`define CESR_ADDR_RSVD       8'h04
`define CESR_ADDR_ACTION     8'h05
`define CESR_ADDR_SUPP_FIRST 8'h06
`define CESR_ADDR_SUPP_SECND 8'h07
`define CESR_ADDR_CONFIG1    8'h08

// Command field positions.
`define CESR_ACT_ENABLE_BIT  0
`define CESR_ACT_APPLY_BIT   1

// Global mask position in the first configuration byte.
`define CESR_CFG_MASK_ALL_BIT 5

// Reset values.
`define CESR_RST_FLAGS       8'h00
`define CESR_RST_ACTION      8'h00
`define CESR_RST_SUPP        8'h00
`define CESR_RST_MASK_ALL    1'b1

// Implemented bits of each byte.
`define CESR_VALID_RAIL      8'h7F
`define CESR_VALID_FIRST     8'hBD
`define CESR_VALID_SECND     8'h7F
`define CESR_VALID_ACTION    8'h01

`endif

// ==== src/cesr_pkg.sv ====
/*
  Types shared by the charger event and status register block.
  Assumes the map header supplies every number.
*/
package cesr_pkg;

    // One byte access from the serial engine.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cesr_reg_req_type;

    // Level sources of the rail fault flags, bit 6 down to bit 0.
    typedef struct packed {
        logic main_over_current;
        logic main_over_voltage;
        logic main_under_voltage;
        logic aux_under_voltage;
        logic bias_over_current;
        logic bias_over_voltage;
        logic bias_under_voltage;
    } cesr_rail_src_type;

    // Live conditions shown in the status byte, bit 7 down to bit 2.
    typedef struct packed {
        logic lock_clock_too_fast;
        logic lock_clock_too_slow;
        logic bias_full_duty;
        logic main_const_current;
        logic main_full_duty;
        logic main_power_good;
    } cesr_live_type;

endpackage

// ==== src/cesr_top.sv ====
/*
  Rail fault flags, live status, command and interrupt mask bytes of
  the charger, with the interrupt output they drive.
  Assumes the serial engine issues one-cycle read and write strobes
  synchronous to CLK_SYS, and that the first flag byte is kept by a
  neighbouring block and presented here as a level vector.
*/
`timescale 1ns/1ns
`include "cesr_map.svh"

module cesr_top (
    // Clock and reset.
    input  wire logic                      CLK_SYS,
    input  wire logic                      RESETN,
    // Byte access from the serial engine.
    input  wire cesr_pkg::cesr_reg_req_type REG_REQ,
    output logic [7:0]                     REG_RDATA,
    // Event and condition sources.
    input  wire cesr_pkg::cesr_rail_src_type RAIL_FAULT_SRC,
    input  wire logic [7:0]                GENERAL_EVENT_FLAGS,
    input  wire cesr_pkg::cesr_live_type   LIVE_COND,
    // Actions and interrupt.
    output logic                           MAIN_REG_ENABLE,
    output logic                           APPLY_VOLTAGE_CODE,
    output logic                           MASK_ALL,
    output logic                           INT_OUT
);

    logic [7:0] rail_flags_q;
    logic [7:0] rail_flags_d;
    logic [7:0] rail_src;
    logic [7:0] live_byte;
    logic [7:0] supp_first_q;
    logic [7:0] supp_second_q;
    logic [7:0] eff_first;
    logic [7:0] eff_second;
    logic [7:0] rdata_d;
    logic       main_en_q;
    logic       apply_q;
    logic       mask_all_q;
    logic       int_q;
    logic       unmasked_any;
    logic       wr_action;
    logic       rd_rail;

    // Decoded strobes for the bytes with side effects.
    assign wr_action = REG_REQ.wr && (REG_REQ.addr == `CESR_ADDR_ACTION);
    assign rd_rail   = REG_REQ.rd
                       && (REG_REQ.addr == `CESR_ADDR_RAIL_FLAGS);

    // Source vector placed at the flag positions; bit 7 has no source.
    assign rail_src = {1'b0, RAIL_FAULT_SRC}; // [RULE_07]

    // Live status byte assembled straight from the monitors.
    assign live_byte = {LIVE_COND, 2'b00}; // [RULE_12]

    // Flag update: clear-on-read only drops bits whose cause is gone,
    // and a source that is active this cycle always sets, so an event
    // in the cycle of a read is never lost.
    always_comb begin
        rail_flags_d = rail_flags_q;
        if (rd_rail) begin
            rail_flags_d = rail_flags_q & rail_src; // [RULE_22]
        end
        rail_flags_d = (rail_flags_d | rail_src)
                       & `CESR_VALID_RAIL; // [RULE_01] [RULE_02] [RULE_03]
    end

    // Sticky rail fault flags.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rail_flags_q <= `CESR_RST_FLAGS;
        end else begin
            rail_flags_q <= rail_flags_d; // [RULE_04] [RULE_05] [RULE_06]
        end
    end

    // Command byte: only the enable bit is stored; apply is a pulse.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            main_en_q <= 1'b0;
        end else if (wr_action) begin
            main_en_q <= REG_REQ.wdata[`CESR_ACT_ENABLE_BIT]; // [RULE_17]
        end
    end

    // Apply pulse for one cycle after a write with bit 1 set.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            apply_q <= 1'b0;
        end else begin
            apply_q <= wr_action
                       && REG_REQ.wdata[`CESR_ACT_APPLY_BIT]; // [RULE_16]
        end
    end

    // Mask bytes; unused positions are never stored and read zero.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            supp_first_q  <= `CESR_RST_SUPP;
            supp_second_q <= `CESR_RST_SUPP;
        end else if (REG_REQ.wr) begin
            if (REG_REQ.addr == `CESR_ADDR_SUPP_FIRST) begin
                supp_first_q <= REG_REQ.wdata
                                & `CESR_VALID_FIRST; // [RULE_20]
            end
            if (REG_REQ.addr == `CESR_ADDR_SUPP_SECND) begin
                supp_second_q <= REG_REQ.wdata
                                 & `CESR_VALID_SECND; // [RULE_21]
            end
        end
    end

    // Global mask bit of the first configuration byte. It starts set so
    // that nothing interrupts the host before it has configured masks.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            mask_all_q <= `CESR_RST_MASK_ALL; // [RULE_23]
        end else if (REG_REQ.wr
                     && (REG_REQ.addr == `CESR_ADDR_CONFIG1)) begin
            mask_all_q <= REG_REQ.wdata[`CESR_CFG_MASK_ALL_BIT];
        end
    end

    // Effective masks: the global bit overrides the stored values.
    assign eff_first  = mask_all_q ? 8'hFF : supp_first_q;  // [RULE_19]
    assign eff_second = mask_all_q ? 8'hFF : supp_second_q; // [RULE_19]

    // Any unmasked flag. Status byte is deliberately not included.
    assign unmasked_any =
        (|(GENERAL_EVENT_FLAGS & `CESR_VALID_FIRST & ~eff_first))
        | (|(rail_flags_q & ~eff_second)); // [RULE_18] [RULE_13]

    // Registered interrupt output, so it is glitch free toward the pin.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            int_q <= 1'b0;
        end else begin
            int_q <= unmasked_any; // [RULE_24]
        end
    end

    // Read multiplexer; unmapped addresses and the reserved byte give
    // zero, and writes to read-only bytes are simply ignored.
    always_comb begin
        case (REG_REQ.addr)
            `CESR_ADDR_RAIL_FLAGS: rdata_d = rail_flags_q;
            `CESR_ADDR_LIVE:       rdata_d = live_byte; // [RULE_13]
            `CESR_ADDR_RSVD:       rdata_d = 8'h00;     // [RULE_14]
            `CESR_ADDR_ACTION:     rdata_d = {7'h00, main_en_q}; // [RULE_16]
            `CESR_ADDR_SUPP_FIRST: rdata_d = supp_first_q;
            `CESR_ADDR_SUPP_SECND: rdata_d = supp_second_q;
            `CESR_ADDR_CONFIG1:    rdata_d = {2'b00, mask_all_q, 5'h00};
            default:               rdata_d = 8'h00;
        endcase
    end

    // Read data register, held until the next read.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            REG_RDATA <= 8'h00;
        end else if (REG_REQ.rd) begin
            REG_RDATA <= rdata_d; // [RULE_08] [RULE_09] [RULE_10] [RULE_11]
        end
    end

    // Output drive.
    assign MAIN_REG_ENABLE    = main_en_q; // [RULE_15]
    assign APPLY_VOLTAGE_CODE = apply_q;
    assign MASK_ALL           = mask_all_q;
    assign INT_OUT            = int_q;

    // Checks on the behaviour above.
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    sequence s_apply_write;
        wr_action && REG_REQ.wdata[`CESR_ACT_APPLY_BIT];
    endsequence

    sequence s_one_pulse;
        APPLY_VOLTAGE_CODE ##1 !APPLY_VOLTAGE_CODE;
    endsequence

    sequence s_read_status;
        REG_REQ.rd && (REG_REQ.addr == `CESR_ADDR_LIVE);
    endsequence

    AST_MAIN_OC_SET: assert property ( // [RULE_01]
        RAIL_FAULT_SRC.main_over_current |=> rail_flags_q[6])
        else $error("Main over-current flag not set.");

    AST_MAIN_OV_SET: assert property ( // [RULE_02]
        RAIL_FAULT_SRC.main_over_voltage |=> rail_flags_q[5])
        else $error("Main over-voltage flag not set.");

    AST_MAIN_UV_SET: assert property ( // [RULE_03]
        RAIL_FAULT_SRC.main_under_voltage |=> rail_flags_q[4])
        else $error("Main under-voltage flag not set.");

    AST_AUX_UV_SET: assert property ( // [RULE_04]
        RAIL_FAULT_SRC.aux_under_voltage |=> rail_flags_q[3])
        else $error("Auxiliary under-voltage flag not set.");

    AST_BIAS_OC_SET: assert property ( // [RULE_05]
        RAIL_FAULT_SRC.bias_over_current |=> rail_flags_q[2])
        else $error("Bias over-current flag not set.");

    AST_BIAS_OV_SET: assert property ( // [RULE_06]
        RAIL_FAULT_SRC.bias_over_voltage |=> rail_flags_q[1])
        else $error("Bias over-voltage flag not set.");

    AST_BIAS_UV_SET: assert property ( // [RULE_07]
        RAIL_FAULT_SRC.bias_under_voltage
        |=> rail_flags_q[0] && !rail_flags_q[7])
        else $error("Bias under-voltage flag wrong.");

    AST_STATUS_LIVE: assert property ( // [RULE_08]
        s_read_status |=> REG_RDATA == {$past(LIVE_COND), 2'b00})
        else $error("Status byte does not show live conditions.");

    AST_RSVD_ZERO: assert property ( // [RULE_14]
        REG_REQ.rd && (REG_REQ.addr == `CESR_ADDR_RSVD)
        |=> REG_RDATA == 8'h00)
        else $error("Reserved byte read nonzero.");

    AST_APPLY_PULSE: assert property ( // [RULE_16]
        s_apply_write ##1 !(wr_action && REG_REQ.wdata[`CESR_ACT_APPLY_BIT])
        |-> s_one_pulse)
        else $error("Apply pulse missing or too long.");

    AST_APPLY_READS_ZERO: assert property ( // [RULE_16]
        REG_REQ.rd && (REG_REQ.addr == `CESR_ADDR_ACTION)
        |=> !REG_RDATA[`CESR_ACT_APPLY_BIT])
        else $error("Apply bit read back as one.");

    AST_ENABLE: assert property ( // [RULE_17]
        wr_action |=> MAIN_REG_ENABLE
                      == $past(REG_REQ.wdata[`CESR_ACT_ENABLE_BIT]))
        else $error("Main enable does not follow command write.");

    AST_MASK_ALL_QUIET: assert property ( // [RULE_19]
        mask_all_q [*2] |-> !INT_OUT)
        else $error("Interrupt raised under global mask.");

    AST_MASK_BLOCKS: assert property ( // [RULE_18]
        mask_all_q
        || (((rail_flags_q & ~supp_second_q) == 8'h00)
            && ((GENERAL_EVENT_FLAGS & `CESR_VALID_FIRST & ~supp_first_q)
                == 8'h00))
        |=> !INT_OUT)
        else $error("Masked flag raised an interrupt.");

    AST_INT_FOLLOWS: assert property ( // [RULE_24]
        !mask_all_q
        && (((rail_flags_q & ~supp_second_q) != 8'h00)
            || ((GENERAL_EVENT_FLAGS & `CESR_VALID_FIRST & ~supp_first_q)
                != 8'h00))
        |=> INT_OUT)
        else $error("Interrupt not raised for an unmasked flag.");

    AST_CLEAR_ON_READ: assert property ( // [RULE_22]
        rd_rail && (rail_src == 8'h00) |=> rail_flags_q == 8'h00)
        else $error("Resolved flags not cleared by read.");

    AST_READ_KEEPS_ACTIVE: assert property ( // [RULE_22]
        rd_rail |=> (rail_flags_q & $past(rail_src)) == $past(rail_src))
        else $error("Active flag lost on read.");

    // A read of the rail flags taken while every cause is gone.
    sequence s_resolved_read;
        rd_rail && (rail_src == 8'h00);
    endsequence

    // Writes that land in the two mask bytes and the global mask bit.
    sequence s_write_first_mask;
        REG_REQ.wr && (REG_REQ.addr == `CESR_ADDR_SUPP_FIRST);
    endsequence

    sequence s_write_second_mask;
        REG_REQ.wr && (REG_REQ.addr == `CESR_ADDR_SUPP_SECND);
    endsequence

    sequence s_write_config;
        REG_REQ.wr && (REG_REQ.addr == `CESR_ADDR_CONFIG1);
    endsequence

    // Once the last cause is read away and the first flag byte has
    // nothing unmasked, the pin must drop; a stuck pin would make the
    // host poll forever.
    AST_INT_RELEASE: assert property ( // [RULE_24]
        s_resolved_read
        ##1 ((GENERAL_EVENT_FLAGS & `CESR_VALID_FIRST & ~eff_first) == 8'h00)
        |=> !INT_OUT)
        else $error("Interrupt held after every flag was resolved.");

    AST_RAIL_TOP_ZERO: assert property ( // [RULE_07]
        rd_rail |=> !REG_RDATA[7])
        else $error("Unused rail flag bit read as one.");

    AST_STATUS_LOW_ZERO: assert property ( // [RULE_12]
        s_read_status |=> REG_RDATA[1:0] == 2'b00)
        else $error("Unused status bits read as one.");

    // Live conditions alone must never reach the pin, even unmasked.
    AST_STATUS_NO_INT: assert property ( // [RULE_13]
        !mask_all_q && (rail_flags_q == 8'h00)
        && ((GENERAL_EVENT_FLAGS & `CESR_VALID_FIRST) == 8'h00)
        |=> !INT_OUT)
        else $error("Status condition raised an interrupt.");

    // The load strobe may only follow a write with the load bit set.
    AST_APPLY_ONLY_ON_WRITE: assert property ( // [RULE_16]
        !(wr_action && REG_REQ.wdata[`CESR_ACT_APPLY_BIT])
        |=> !APPLY_VOLTAGE_CODE)
        else $error("Spurious apply pulse.");

    // Only a command write may move the regulator enable.
    AST_ENABLE_HOLDS: assert property ( // [RULE_15]
        !wr_action |=> $stable(MAIN_REG_ENABLE))
        else $error("Main enable moved without a command write.");

    AST_ACTION_UPPER_ZERO: assert property ( // [RULE_17]
        REG_REQ.rd && (REG_REQ.addr == `CESR_ADDR_ACTION)
        |=> REG_RDATA[7:1] == 7'h00)
        else $error("Unused command bits read as one.");

    // Mask writes keep only the implemented positions.
    AST_FIRST_MASK_WRITE: assert property ( // [RULE_20]
        s_write_first_mask
        |=> supp_first_q == ($past(REG_REQ.wdata) & `CESR_VALID_FIRST))
        else $error("First mask byte stored wrongly.");

    AST_SECOND_MASK_WRITE: assert property ( // [RULE_21]
        s_write_second_mask
        |=> supp_second_q == ($past(REG_REQ.wdata) & `CESR_VALID_SECND))
        else $error("Second mask byte stored wrongly.");

    AST_MASK_ALL_WRITE: assert property ( // [RULE_19]
        s_write_config
        |=> MASK_ALL == $past(REG_REQ.wdata[`CESR_CFG_MASK_ALL_BIT]))
        else $error("Global mask bit not taken from the write.");

    // Without a read a flag never drops, so no event is lost before
    // the host has seen it.
    AST_FLAGS_STICKY: assert property ( // [RULE_22]
        !rd_rail
        |=> (rail_flags_q & $past(rail_flags_q)) == $past(rail_flags_q))
        else $error("Rail flag dropped without a read.");

endmodule // cesr_top

// ==== sim/cesr_host_model.sv ====
/*
  Host model that issues single byte accesses to the register block.
  Assumes one-cycle strobes that are taken on the rising clock edge.
*/
`timescale 1ns/1ns

module cesr_host_model (
    // Clock.
    input  logic                       clk,
    // Register bus.
    output cesr_pkg::cesr_reg_req_type req,
    input  logic [7:0]                 rdata
);
    // The bus starts idle with no strobe raised.
    initial req = '0;

    // One access; an idle bus carries inverted fields so stale data
    // can never pass for a valid request.
    task automatic xfer(input logic w, r, input logic [7:0] a, d,
                        output logic [7:0] q);
        @(posedge clk);
        req <= {w, r, a, d};
        @(posedge clk);
        req <= {1'b0, 1'b0, ~a, ~d};
        #1 q = rdata;
    endtask
endmodule // cesr_host_model

// ==== sim/cesr_testbench.sv ====
/*
  Self-checking testbench of the event, status and command bytes.
  Assumes the host model drives the register bus and the bench drives
  every event and condition source.
*/
`timescale 1ns/1ns

module testbench;
    // Clock, reset and design signals.
    logic                        clk = 1'b0;
    logic                        rstn = 1'b0;
    cesr_pkg::cesr_reg_req_type  req;
    logic [7:0]                  rdata;
    cesr_pkg::cesr_rail_src_type src = '0;
    logic [7:0]                  gen = 8'h00;
    cesr_pkg::cesr_live_type     live = '0;
    logic                        en, apply, mask_all, int_o;
    logic [7:0]                  q;
    int                          bad_count = 0;
    int                          n_checks = 0;

    // Clock at 20 MHz.
    initial forever #25 clk = ~clk;

    cesr_top DUT (.CLK_SYS(clk), .RESETN(rstn), .REG_REQ(req),
        .REG_RDATA(rdata), .RAIL_FAULT_SRC(src),
        .GENERAL_EVENT_FLAGS(gen), .LIVE_COND(live),
        .MAIN_REG_ENABLE(en), .APPLY_VOLTAGE_CODE(apply),
        .MASK_ALL(mask_all), .INT_OUT(int_o));

    cesr_host_model host (.clk(clk), .req(req), .rdata(rdata));

    // Comparison of one observed value against its expectation.
    task automatic chk(input logic [7:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask

    task automatic rdchk(input logic [7:0] a, exp);
        host.xfer(1'b0, 1'b1, a, 8'h00, q);
        chk(q, exp);
    endtask

    task automatic wr(input logic [7:0] a, d);
        host.xfer(1'b1, 1'b0, a, d, q);
    endtask

    // Two edges let a new source reach the flag and then the interrupt.
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        chkb(mask_all, 1'b1);
        chkb(int_o, 1'b0);
        for (int a = 2; a < 8; a++) rdchk(8'(a), 8'h00);
        rdchk(8'h08, 8'h20);
        $display("test reset done");
    endtask

    // Each rail source sets its own flag; clearing waits for the cause.
    task automatic t_rail();
        for (int i = 0; i < 7; i++) begin
            @(posedge clk) src <= 7'(1 << i);
            settle();
            chkb(int_o, 1'b0);
            rdchk(8'h02, 8'(1 << i));
            @(posedge clk) src <= '0;
            rdchk(8'h02, 8'(1 << i));
            rdchk(8'h02, 8'h00);
        end
        $display("test rail flags done");
    endtask

    task automatic t_mask();
        wr(8'h08, 8'h00);
        chkb(mask_all, 1'b0);
        @(posedge clk) src <= 7'h20;
        settle();
        chkb(int_o, 1'b1);
        wr(8'h07, 8'h20);
        settle();
        chkb(int_o, 1'b0);
        wr(8'h07, 8'hFF);
        rdchk(8'h07, 8'h7F);
        @(posedge clk) src <= '0;
        rdchk(8'h02, 8'h20);
        wr(8'h07, 8'h00);
        @(posedge clk) gen <= 8'h80;
        settle();
        chkb(int_o, 1'b1);
        wr(8'h06, 8'hFF);
        rdchk(8'h06, 8'hBD);
        settle();
        chkb(int_o, 1'b0);
        wr(8'h06, 8'h00);
        wr(8'h08, 8'h20);
        settle();
        chkb(int_o, 1'b0);
        wr(8'h08, 8'h00);
        settle();
        chkb(int_o, 1'b1);
        @(posedge clk) gen <= 8'h00;
        settle();
        chkb(int_o, 1'b0);
        $display("test masks done");
    endtask

    // Live conditions appear at bits 7 to 2 and never interrupt.
    task automatic t_live();
        for (int i = 0; i < 6; i++) begin
            @(posedge clk) live <= 6'(1 << i);
            settle();
            rdchk(8'h03, 8'(1 << (i + 2)));
            chkb(int_o, 1'b0);
        end
        wr(8'h03, 8'hFF);
        rdchk(8'h03, 8'h80);
        @(posedge clk) live <= '0;
        wr(8'h04, 8'hFF);
        rdchk(8'h04, 8'h00);
        rdchk(8'h40, 8'h00);
        $display("test status done");
    endtask

    // The load bit pulses once and reads zero; enable follows bit 0.
    task automatic t_cmd();
        wr(8'h05, 8'h03);
        chkb(en, 1'b1);
        chkb(apply, 1'b1);
        @(posedge clk) #1;
        chkb(apply, 1'b0);
        rdchk(8'h05, 8'h01);
        wr(8'h05, 8'hFC);
        chkb(en, 1'b0);
        chkb(apply, 1'b0);
        rdchk(8'h05, 8'h00);
        $display("test command done");
    endtask

    // A mid-run reset returns the command and global mask to defaults.
    task automatic t_rerst();
        wr(8'h05, 8'h01);
        wr(8'h08, 8'h00);
        @(posedge clk) rstn <= 1'b0;
        @(posedge clk) #1;
        chkb(en, 1'b0);
        chkb(mask_all, 1'b1);
        chkb(int_o, 1'b0);
        @(posedge clk) rstn <= 1'b1;
        rdchk(8'h05, 8'h00);
        rdchk(8'h08, 8'h20);
        $display("test second reset done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence after ten cycles of reset.
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        #1;
        t_reset();
        t_rail();
        t_mask();
        t_live();
        t_cmd();
        t_rerst();
        conclude();
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        #(50 * 5000);
        bad_count++;
        conclude();
    end
endmodule // testbench
